// >>> logic/step_dir_pkg.sv
// Shared constants and types for the step/direction position error block
package step_dir_pkg;
    // Position counter width
    localparam int POS_W = 32;
    // Error output code width, 0..2.5 V full scale
    localparam int ERR_W = 8;
    // Error code for zero error, the midscale level
    localparam logic [ERR_W-1:0] ERR_MID = 8'h80;
    // Highest and lowest error codes
    localparam logic [ERR_W-1:0] ERR_MAX = 8'hFF;
    localparam logic [ERR_W-1:0] ERR_MIN = 8'h00;
    // Signed error limits that still fit the output span
    localparam int ERR_SPAN_HI = 127;
    localparam int ERR_SPAN_LO = -128;
    // Fault limit on the error magnitude, in counts
    localparam int FAULT_LIMIT = 128;
    // Reset value of both positions
    localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;
    // Inertia modes
    typedef enum logic {INERTIA_LOW, INERTIA_HIGH} inertia_t;
endpackage : step_dir_pkg

// >>> logic/sync_edge.sv
// Two-flop synchroniser with a rising edge pulse on the synchronised level
`timescale 1ns/1ps
`default_nettype none
module sync_edge #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic async,
    output logic level,
    output logic rise
);
    // All state in one record
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
    } sync_state_t;

    sync_state_t st_q;
    sync_state_t st_d;

    ////////////////////////////////////////////////////////////////////
    // Next state: s1 feeds only s2
    always_comb begin
        st_d = st_q;
        st_d.s1 = async;
        st_d.s2 = st_q.s1;
        st_d.prev = st_q.s2;
    end

    // Register the record
    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= '{s1: RESET_VAL, s2: RESET_VAL, prev: RESET_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign level = st_q.s2;
    assign rise = st_q.s2 & ~st_q.prev;
endmodule : sync_edge
`default_nettype wire

// >>> logic/quad_decoder.sv
// Times-four quadrature decoder giving an up/down count pulse
`timescale 1ns/1ps
`default_nettype none
module quad_decoder (
    input wire logic clk,
    input wire logic srst,
    input wire logic chanA,
    input wire logic chanB,
    output logic countUp,
    output logic countDown
);
    // Synchronised channels and last sampled pair
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] last;
    } quad_state_t;

    quad_state_t st_q;
    quad_state_t st_d;
    logic [3:0] trans;

    ////////////////////////////////////////////////////////////////////
    // Synchronise both channels; every edge of either counts
    always_comb begin
        st_d = st_q;
        st_d.s1 = {chanA, chanB};
        st_d.s2 = st_q.s1;
        st_d.last = st_q.s2;
    end

    // Register the record
    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Gray sequence 00-01-11-10 is one way, the reverse the other
    assign trans = {st_q.last, st_q.s2};
    always_comb begin
        countUp = 1'b0;
        countDown = 1'b0;
        unique case (trans)
            4'h1, 4'h7, 4'hE, 4'h8: countUp = 1'b1;
            4'h2, 4'hB, 4'hD, 4'h4: countDown = 1'b1;
            // No change, or a double step that cannot be resolved
            default: begin
                countUp = 1'b0;
                countDown = 1'b0;
            end
        endcase
    end
endmodule : quad_decoder
`default_nettype wire

// >>> logic/step_dir_position_error.sv
// Step/direction commanded position, encoder position and error output
`timescale 1ns/1ps
`default_nettype none
//
// Behaviour
// - Latch direction on step rising edge only
// - Direction low steps command clockwise
// - Direction high or open steps counter-clockwise
// - One increment per step rising edge only
// - One increment equals one decoded encoder count
// - High or low inertia, low by default
// - Zero error shows as midscale output
// - One code step per count, up means clockwise
// - Output stays inside the -128..+127 count span
// - Encoder decoded on every edge, four per line
// - Fault when error magnitude exceeds limit
module step_dir_position_error
    import step_dir_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic stepIn,
    input wire logic dirIn,
    input wire logic encA,
    input wire logic encB,
    input wire logic inertiaHighSel,
    input wire logic inertiaLowSel,
    output logic [step_dir_pkg::ERR_W-1:0] errCode,
    output logic errFault,
    output logic inertiaHigh,
    output logic [step_dir_pkg::POS_W-1:0] cmdPos,
    output logic [step_dir_pkg::POS_W-1:0] actPos,
    output logic [step_dir_pkg::POS_W-1:0] posError
);
    import step_dir_pkg::*;

    // Whole state of the block
    typedef struct packed {
        logic [POS_W-1:0] cmd;
        logic [POS_W-1:0] act;
        logic [POS_W-1:0] err;
        logic [ERR_W-1:0] code;
        logic fault;
        logic inertia;
        logic [1:0] hiSync;
        logic [1:0] loSync;
    } top_state_t;

    top_state_t st_q;
    top_state_t st_d;

    // Synchronised command inputs
    logic stepLevel;
    logic stepRise;
    logic dirLevel;
    // Encoder count pulses
    logic encUp;
    logic encDown;
    // Next error as a signed value
    logic signed [POS_W-1:0] errNext;

    ////////////////////////////////////////////////////////////////////
    // Input conditioning

    // Step pin; only the rising edge is used
    sync_edge #(.RESET_VAL(1'b0)) stepSync (
        .clk(clk),
        .srst(srst),
        .async(stepIn),
        .level(stepLevel),
        .rise(stepRise)
    );

    // Direction pin; open input pulls high so reset value is one
    sync_edge #(.RESET_VAL(1'b1)) dirSync (
        .clk(clk),
        .srst(srst),
        .async(dirIn),
        .level(dirLevel),
        .rise()
    );

    // Encoder decoded on every channel edge
    quad_decoder encDec (
        .clk(clk),
        .srst(srst),
        .chanA(encA),
        .chanB(encB),
        .countUp(encUp),
        .countDown(encDown)
    );

    ////////////////////////////////////////////////////////////////////
    // Saturating map of signed error to the output code
    function automatic logic [ERR_W-1:0] err_to_code(input logic signed [POS_W-1:0] e);
        logic [ERR_W-1:0] c;
        c = ERR_MID;
        if (e > POS_W'(ERR_SPAN_HI)) begin
            c = ERR_MAX;
        end else if (e < POS_W'(ERR_SPAN_LO)) begin
            c = ERR_MIN;
        end else begin
            c = ERR_MID + e[ERR_W-1:0];
        end
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_d = st_q;
        // Direction is sampled in the same cycle as the synced step edge;
        // both paths share two stages so skew between them is kept equal
        if (stepRise) begin
            if (!dirLevel) begin
                st_d.cmd = st_q.cmd + 1'b1;
            end else begin
                st_d.cmd = st_q.cmd - 1'b1;
            end
        end
        // Encoder counts in the same units as commanded steps
        if (encUp) begin
            st_d.act = st_q.act + 1'b1;
        end else if (encDown) begin
            st_d.act = st_q.act - 1'b1;
        end
        // Positive error means the shaft sits clockwise of command
        errNext = $signed(st_d.act - st_d.cmd);
        st_d.err = errNext;
        // Midscale at zero, clamped at the span ends
        st_d.code = err_to_code(errNext);
        // Fault is sticky until reset
        if ((errNext > POS_W'(FAULT_LIMIT)) || (errNext < -POS_W'(FAULT_LIMIT))) begin
            st_d.fault = 1'b1;
        end
        // Inertia strap: high only when high alone is selected
        st_d.hiSync = {st_q.hiSync[0], inertiaHighSel};
        st_d.loSync = {st_q.loSync[0], inertiaLowSel};
        if (st_q.hiSync[1] && !st_q.loSync[1]) begin
            st_d.inertia = INERTIA_HIGH;
        end else begin
            st_d.inertia = INERTIA_LOW;
        end
    end

    // Register the record
    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= '{cmd: POS_RESET, act: POS_RESET, err: POS_RESET, code: ERR_MID,
                      fault: 1'b0, inertia: INERTIA_LOW, hiSync: 2'h0, loSync: 2'h0};
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs straight from flops; the loop compensator that zeroes the
    // error sits outside and consumes posError/errCode
    assign errCode = st_q.code;
    assign errFault = st_q.fault;
    assign inertiaHigh = st_q.inertia;
    assign cmdPos = st_q.cmd;
    assign actPos = st_q.act;
    assign posError = st_q.err;
endmodule : step_dir_position_error
`default_nettype wire

// >>> bench/step_dir_chk.sv
// Concurrent checks on the ports of the position error block
`timescale 1ns/1ps
`default_nettype none
module step_dir_chk
    import step_dir_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic stepIn,
    input wire logic inertiaHighSel,
    input wire logic inertiaLowSel,
    input wire logic [step_dir_pkg::ERR_W-1:0] errCode,
    input wire logic errFault,
    input wire logic inertiaHigh,
    input wire logic [step_dir_pkg::POS_W-1:0] cmdPos,
    input wire logic [step_dir_pkg::POS_W-1:0] actPos,
    input wire logic [step_dir_pkg::POS_W-1:0] posError
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    logic signed [31:0] err; // Error as a signed count
    logic big; // Error magnitude past the fault limit
    logic stepPrev_q;
    logic [3:0] stepAge_q; // Cycles since a step rise, saturating
    assign err = $signed(posError);
    assign big = (err > FAULT_LIMIT) || (err < -FAULT_LIMIT);
    // Age of the last step rise; command moves only shortly after one
    always_ff @(posedge clk) begin
        stepPrev_q <= stepIn;
        if (srst) begin
            stepAge_q <= 4'hF;
        end else if (stepIn && !stepPrev_q) begin
            stepAge_q <= 4'h0;
        end else if (stepAge_q != 4'hF) begin
            stepAge_q <= stepAge_q + 4'h1;
        end
    end
    // Jumper patterns held long enough to pass the synchronisers
    sequence hiOnly; (inertiaHighSel && !inertiaLowSel) [*5]; endsequence
    sequence notHiOnly; !(inertiaHighSel && !inertiaLowSel) [*5]; endsequence
    chk_err_linear: assert property ((err <= ERR_SPAN_HI && err >= ERR_SPAN_LO) |-> errCode == (posError[7:0] ^ 8'h80))
        else $error("error code not midscale plus error");
    chk_sat_high: assert property (err > ERR_SPAN_HI |-> errCode == ERR_MAX)
        else $error("error code not clamped high");
    chk_sat_low: assert property (err < ERR_SPAN_LO |-> errCode == ERR_MIN)
        else $error("error code not clamped low");
    chk_err_diff: assert property (posError == actPos - cmdPos)
        else $error("error is not actual minus command");
    chk_cmd_unit: assert property ($changed(cmdPos) |-> (cmdPos - $past(cmdPos)) inside {32'h1, 32'hFFFF_FFFF})
        else $error("command moved by more than one");
    chk_step_cause: assert property ($changed(cmdPos) |-> stepAge_q <= 4'h6)
        else $error("command moved without a step rise");
    chk_fault_hold: assert property (errFault |=> errFault)
        else $error("fault dropped without reset");
    chk_fault_set: assert property (big |-> ##[0:2] errFault)
        else $error("fault missing on large error");
    chk_fault_cause: assert property ($rose(errFault) |-> big || $past(big))
        else $error("fault raised on small error");
    chk_inert_high: assert property (hiOnly |-> inertiaHigh)
        else $error("high inertia not selected");
    chk_inert_low: assert property (notHiOnly |-> !inertiaHigh)
        else $error("low inertia not selected");
endmodule // step_dir_chk
`default_nettype wire

// >>> bench/step_source_model.sv
// Indexer model issuing step pulses with a direction level
`timescale 1ns/1ps
`default_nettype none
module step_source_model (
    input wire logic clk,
    output var logic stepIn,
    output var logic dirIn
);
    // Idle: no step, direction released
    initial begin
        stepIn = 1'b0;
        dirIn = 1'b1; // Open line reads high
    end
    // One step; direction flips while step is high to prove it is latched
    task automatic pulse(input logic d);
        @(negedge clk) dirIn = d;
        repeat (3) @(negedge clk);
        stepIn = 1'b1;
        repeat (2) @(negedge clk);
        dirIn = ~d;
        repeat (2) @(negedge clk);
        stepIn = 1'b0;
        repeat (2) @(negedge clk);
        dirIn = 1'b1; // Released line pulls high
    endtask
endmodule // step_source_model
`default_nettype wire

// >>> bench/step_dir_position_error_tb.sv
// Self-checking bench for the step/direction position error block
`timescale 1ns/1ps
`default_nettype none
module step_dir_position_error_tb;
    import step_dir_pkg::*;
    logic clk = 1'b0, srst = 1'b1, encA = 1'b0, encB = 1'b0, inertiaHighSel = 1'b0, inertiaLowSel = 1'b0;
    wire logic stepIn, dirIn;
    logic [ERR_W-1:0] errCode;
    logic errFault, inertiaHigh;
    logic [POS_W-1:0] cmdPos, actPos, posError;
    int num_errors = 0, total_checks = 0, cycles = 0, encIdx = 0;
    step_dir_position_error u_step_dir_position_error (.clk(clk), .srst(srst), .stepIn(stepIn), .dirIn(dirIn),
        .encA(encA), .encB(encB), .inertiaHighSel(inertiaHighSel), .inertiaLowSel(inertiaLowSel),
        .errCode(errCode), .errFault(errFault), .inertiaHigh(inertiaHigh), .cmdPos(cmdPos), .actPos(actPos),
        .posError(posError));
    step_source_model u_src (.clk(clk), .stepIn(stepIn), .dirIn(dirIn));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    // Positions and error code against values worked out here
    task automatic cmpAll(input int c, input int a);
        int e;
        e = a - c;
        idle(6);
        cmp("cmdPos", 32'(c), cmdPos);
        cmp("actPos", 32'(a), actPos);
        cmp("errCode", (e > 127) ? 32'hFF : (e < -128) ? 32'h0 : 32'(e + 128), 32'(errCode));
    endtask
    // Encoder walk, one channel at a time: 00 01 11 10 counts up
    task automatic enc(input int up, input int n);
        repeat (n) begin
            encIdx = (encIdx + (up ? 1 : 3)) % 4;
            {encA, encB} = 2'(encIdx ^ (encIdx >> 1));
            idle(3);
        end
    endtask
    task automatic t_reset();
        srst = 1'b1;
        idle(3);
        srst = 1'b0;
        cmpAll(0, 0);
        cmp("errFault", 32'h0, 32'(errFault));
    endtask
    task automatic t_steps();
        repeat (3) u_src.pulse(1'b0);
        cmpAll(3, 0);
        repeat (5) u_src.pulse(1'b1);
        cmpAll(-2, 0);
    endtask
    task automatic t_track();
        enc(1, 4);
        cmpAll(-2, 4);
        repeat (6) u_src.pulse(1'b0);
        cmpAll(4, 4);
        enc(0, 3);
        cmpAll(4, 1);
    endtask
    // Fault limit boundary, clamping both ways, fault held until reset
    task automatic t_fault();
        enc(1, 131);
        cmpAll(4, 132);
        cmp("errFault", 32'h0, 32'(errFault));
        enc(1, 1);
        cmpAll(4, 133);
        cmp("errFault", 32'h1, 32'(errFault));
        enc(0, 261);
        cmpAll(4, -128);
        cmp("errFault", 32'h1, 32'(errFault));
    endtask
    task automatic t_inertia();
        for (int i = 0; i < 4; i++) begin
            {inertiaHighSel, inertiaLowSel} = 2'(i); // Pattern 3 breaks the jumper
            idle(8);
            cmp("inertiaHigh", 32'(i == 2), 32'(inertiaHigh));
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        t_reset();
        t_steps();
        t_track();
        t_fault();
        t_reset();
        t_inertia();
        end_of_test();
    end
    // Hang guard well beyond the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
endmodule // step_dir_position_error_tb
bind step_dir_position_error step_dir_chk u_chk (.clk(clk), .srst(srst), .stepIn(stepIn),
    .inertiaHighSel(inertiaHighSel), .inertiaLowSel(inertiaLowSel), .errCode(errCode), .errFault(errFault),
    .inertiaHigh(inertiaHigh), .cmdPos(cmdPos), .actPos(actPos), .posError(posError));
`default_nettype wire
